// ### bench/pcel_link_model.sv
// Purpose: link and physical layer partner that raises error events
// Assumes: each event is one high cycle on aclk, changed after a rising edge
// Notes: event lines rest low between pulses; pending is a level
`timescale 1ns/1ns
module pcel_link_model (
  input wire logic aclk,
  output logic tlp_pending,
  output logic ack_nak_rx,
  output logic replay_start,
  output logic dllp_crc_bad,
  output logic tlp_crc_bad,
  output logic tlp_code_err,
  output logic seq_num_bad,
  output logic rx_code_err,
  output logic rx_frame_err
);
  logic pend_q; // unacknowledged traffic level
  logic [7:0] ev_q; // one bit per event line, indexed as in pulse
  // ------------------------------------------------------------
  // idle state at time zero
  // ------------------------------------------------------------
  initial begin
    pend_q = 1'b0;
    ev_q = 8'h00;
  end
  // each source is its own port, so every design input is exercised
  assign tlp_pending = pend_q;
  assign ack_nak_rx = ev_q[0];
  assign replay_start = ev_q[1];
  assign dllp_crc_bad = ev_q[2];
  assign tlp_crc_bad = ev_q[3];
  assign tlp_code_err = ev_q[4];
  assign seq_num_bad = ev_q[5];
  assign rx_code_err = ev_q[6];
  assign rx_frame_err = ev_q[7];
  // one high cycle per event, so the block counts each pulse once
  task automatic pulse(input int k);
    @(posedge aclk);
    ev_q[k] <= 1'b1;
    @(posedge aclk);
    ev_q[k] <= 1'b0;
  endtask
  // unacknowledged traffic level, lets the replay timer run or stop
  task automatic hold_pending(input logic v);
    @(posedge aclk);
    pend_q <= v;
  endtask
endmodule

// ### bench/pcel_top_tb_top.sv
// Purpose: self-checking bench for the correctable error log
// Assumes: axi4-lite master tasks, partner model gives event pulses
// Notes: expected words come from the bit positions of the two registers
`timescale 1ns/1ns
module pcel_top_tb_top;
  import pcel_pkg::*;
  logic aclk, aresetn, pwr_on_rst_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, cor_err_msg, irq, tlp_pending;
  logic [1:0] bresp, rresp;
  logic ack_nak_rx, replay_start, dllp_crc_bad, tlp_crc_bad;
  logic tlp_code_err, seq_num_bad, rx_code_err, rx_frame_err;
  logic [3:0] wstrb;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  // status word each event should leave behind, indexed by event line
  logic [31:0] ev_bits [8] = '{0, 0, 32'h80, 32'h40, 32'hc1, 32'hc0, 32'h01, 32'h01};
  // ------------------------------------------------------------
  // clock, design and partner
  // ------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  pcel_top i_pcel_top (.aclk(aclk), .aresetn(aresetn), .pwr_on_rst_n(pwr_on_rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tlp_pending(tlp_pending), .ack_nak_rx(ack_nak_rx), .replay_start(replay_start),
    .dllp_crc_bad(dllp_crc_bad), .tlp_crc_bad(tlp_crc_bad), .tlp_code_err(tlp_code_err),
    .seq_num_bad(seq_num_bad), .rx_code_err(rx_code_err), .rx_frame_err(rx_frame_err),
    .cor_err_msg(cor_err_msg), .irq(irq));
  pcel_link_model i_pcel_link_model (.aclk(aclk), .tlp_pending(tlp_pending),
    .ack_nak_rx(ack_nak_rx), .replay_start(replay_start), .dllp_crc_bad(dllp_crc_bad),
    .tlp_crc_bad(tlp_crc_bad), .tlp_code_err(tlp_code_err), .seq_num_bad(seq_num_bad),
    .rx_code_err(rx_code_err), .rx_frame_err(rx_frame_err));
  // ------------------------------------------------------------
  // compare and bus tasks
  // ------------------------------------------------------------
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1;
        chk_word($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
      end
    end
    bready <= 1'b0;
  endtask
  // rready held high until the data beat is seen
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1;
        chk_word($sformatf("rdata %h", a), e, rdata);
        chk_word($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
      end
    end
    rready <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // hang guard, the whole run needs well under this many cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      finish_test;
    end
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    pwr_on_rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    pwr_on_rst_n <= 1'b1;
    // handshake outputs idle after reset
    #1;
    chk_bit("awready", 1'b1, awready);
    chk_bit("wready", 1'b1, wready);
    chk_bit("arready", 1'b1, arready);
    chk_bit("bvalid", 1'b0, bvalid);
    chk_bit("rvalid", 1'b0, rvalid);
    chk_bit("irq", 1'b0, irq);
    chk_bit("cor_err_msg", 1'b0, cor_err_msg);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(OFF_MASK, 32'h0, RESP_OKAY);
    rd(OFF_CAPCTL, 32'h0, RESP_OKAY);
    // read-only words ignore writes but answer okay
    wr(OFF_CAPCTL, 32'hffffffff, RESP_OKAY);
    rd(OFF_CAPCTL, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_STS, 32'hffffffff, RESP_OKAY);
    rd(OFF_IRQ_STS, 32'h0, RESP_OKAY);
    rd(12'h200, 32'h0, RESP_SLVERR);
    wr(12'h200, 32'hffffffff, RESP_SLVERR);
    wr(OFF_MASK, 32'hffffffff, RESP_OKAY);
    rd(OFF_MASK, 32'h000011c1, RESP_OKAY);
    // byte strobes: only the low lane is written
    wstrb <= 4'h1;
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    wstrb <= 4'hf;
    rd(OFF_MASK, 32'h00001100, RESP_OKAY);
    wr(OFF_MASK, 32'h0, RESP_OKAY);
    wr(OFF_STATUS, 32'hffffffff, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    // every error line, dllp_crc_bad to rx_frame_err, reported, logged and cleared
    for (int k = 2; k < 8; k++) begin
      i_pcel_link_model.pulse(k);
      #1;
      chk_bit("cor_err_msg", 1'b1, cor_err_msg);
      rd(OFF_STATUS, ev_bits[k], RESP_OKAY);
      wr(OFF_STATUS, ev_bits[k], RESP_OKAY);
      rd(OFF_STATUS, 32'h0, RESP_OKAY);
    end
    // partial clear and zero writes leave other bits alone
    i_pcel_link_model.pulse(2);
    i_pcel_link_model.pulse(3);
    wr(OFF_STATUS, 32'h40, RESP_OKAY);
    wr(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h80, RESP_OKAY);
    wr(OFF_STATUS, 32'h80, RESP_OKAY);
    // masked event is logged but not reported
    wr(OFF_MASK, 32'h80, RESP_OKAY);
    i_pcel_link_model.pulse(2);
    #1;
    chk_bit("cor_err_msg", 1'b0, cor_err_msg);
    rd(OFF_STATUS, 32'h80, RESP_OKAY);
    // interrupt: clear, enable one source, raise, clear again
    wr(OFF_IRQ_CLR, 32'h000011c1, RESP_OKAY);
    rd(OFF_IRQ_STS, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_EN, 32'h40, RESP_OKAY);
    i_pcel_link_model.pulse(2);
    #1;
    chk_bit("irq", 1'b0, irq);
    rd(OFF_IRQ_STS, 32'h80, RESP_OKAY);
    i_pcel_link_model.pulse(3);
    #1;
    chk_bit("cor_err_msg", 1'b1, cor_err_msg);
    chk_bit("irq", 1'b1, irq);
    rd(OFF_IRQ_CLR, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_CLR, 32'h40, RESP_OKAY);
    @(posedge aclk);
    #1;
    chk_bit("irq", 1'b0, irq);
    // ordinary reset keeps the log, power-up reset empties it
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STATUS, 32'hc0, RESP_OKAY);
    rd(OFF_MASK, 32'h80, RESP_OKAY);
    rd(OFF_IRQ_EN, 32'h0, RESP_OKAY);
    pwr_on_rst_n <= 1'b0;
    repeat (5) @(posedge aclk);
    pwr_on_rst_n <= 1'b1;
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(OFF_MASK, 32'h0, RESP_OKAY);
    // retransmission count: an ack restarts it, the fourth wraps it
    i_pcel_link_model.pulse(0);
    repeat (3) i_pcel_link_model.pulse(1);
    i_pcel_link_model.pulse(0);
    repeat (3) i_pcel_link_model.pulse(1);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    i_pcel_link_model.pulse(1);
    rd(OFF_STATUS, 32'h100, RESP_OKAY);
    wr(OFF_STATUS, 32'h100, RESP_OKAY);
    // replay timer expires only after its full span; an ack midway restarts it
    i_pcel_link_model.pulse(0);
    i_pcel_link_model.hold_pending(1'b1);
    repeat (100) @(posedge aclk);
    i_pcel_link_model.pulse(0);
    repeat (190) @(posedge aclk);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    repeat (15) @(posedge aclk);
    rd(OFF_STATUS, 32'h1000, RESP_OKAY);
    i_pcel_link_model.hold_pending(1'b0);
    finish_test;
  end
endmodule

// ### design/pcel_pkg.sv
// Purpose: constants for the correctable error log register bank
// Assumes: 100 MHz aclk, AXI4-Lite with 12-bit byte addresses
// Notes: status and mask live in a compact 5-bit form inside the block
package pcel_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS = 12'h110; // correctable_error_status
  localparam logic [11:0] OFF_MASK = 12'h114; // correctable_error_mask
  localparam logic [11:0] OFF_CAPCTL = 12'h118; // advanced_error_cap_control
  localparam logic [11:0] OFF_IRQ_EN = 12'h130; // interrupt enable
  localparam logic [11:0] OFF_IRQ_CLR = 12'h134; // interrupt clear, write only
  localparam logic [11:0] OFF_IRQ_STS = 12'h138; // interrupt status, read only
  // ------------------------------------------------------------
  // bit positions in the 32-bit word
  // ------------------------------------------------------------
  localparam int POS_RCV = 0; // receiver error
  localparam int POS_TLP = 6; // bad tlp
  localparam int POS_DLLP = 7; // bad dllp
  localparam int POS_RNUM = 8; // replay count rollover
  localparam int POS_RTO = 12; // replay timer timeout
  // index in the compact vector
  localparam int I_RCV = 0;
  localparam int I_TLP = 1;
  localparam int I_DLLP = 2;
  localparam int I_RNUM = 3;
  localparam int I_RTO = 4;
  localparam int NEV = 5; // number of implemented errors
  // implemented bits, everything else reads zero
  localparam logic [31:0] IMPL_BITS = 32'h000011c1;
  // ------------------------------------------------------------
  // reset values and responses
  // ------------------------------------------------------------
  localparam logic [NEV-1:0] RST_STATUS = 5'h00;
  localparam logic [NEV-1:0] RST_MASK = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 10; // aclk period
  localparam int REPLAY_TIME_NS = 2000; // replay timer span
  localparam logic [7:0] REPLAY_CYC = 8'((REPLAY_TIME_NS / CLK_NS));
  localparam logic [1:0] RNUM_LAST = 2'h3; // count value before wrap
endpackage

// ### design/pcel_top.sv
// Purpose: correctable error log, mask, reporting and interrupt
// Assumes: error sources are pulses on aclk; aresetn is ordinary reset
// Notes: pwr_on_rst_n alone clears the sticky status and mask
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
// Functional notes
// - status bits stay set until written one
// - status and mask survive ordinary reset
// - replay timer expiry sets bit 12
// - two-bit replay count wrap sets bit 8
// - dllp crc mismatch sets bit 7
// - tlp crc mismatch sets bit 6
// - code errors in tlp set bits 7, 6, 0
// - bad sequence number sets bits 7, 6
// - any code or framing error sets bit 0
// - masked errors send no error message
// - masked errors are still logged
// - mask bits at 12, 8, 7, 6, 0
// - mask bits start at zero
// - status register at offset 0x110
module pcel_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pwr_on_rst_n, // power-up reset, active low
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link and physical layer events
  input wire logic tlp_pending, // unacknowledged tlps outstanding
  input wire logic ack_nak_rx, // ack or nak dllp received
  input wire logic replay_start, // retry buffer retransmission begins
  input wire logic dllp_crc_bad, // dllp crc mismatch
  input wire logic tlp_crc_bad, // tlp crc mismatch
  input wire logic tlp_code_err, // 8b/10b or disparity error in a tlp
  input wire logic seq_num_bad, // invalid sequence number
  input wire logic rx_code_err, // 8b/10b error anywhere
  input wire logic rx_frame_err, // framing error anywhere
  // reporting
  output logic cor_err_msg, // pulse: send correctable error message
  output logic irq // level interrupt
);
  import pcel_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NEV-1:0] sts; // correctable status, sticky
    logic [NEV-1:0] msk; // report mask, sticky
    logic [NEV-1:0] ien; // interrupt enable
    logic [NEV-1:0] ist; // interrupt status
    logic [7:0] timer; // replay timer
    logic [1:0] rnum; // replay count
    logic aw_held; // write address captured
    logic [11:0] aw_addr;
    logic w_held; // write data captured
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic err_msg;
    logic irq;
  } pcel_state_type;

  pcel_state_type st; // registered state
  pcel_state_type next_st; // next state
  pcel_state_type por_st; // power-up values
  pcel_state_type soft_st; // ordinary-reset values, log and mask kept

  logic [NEV-1:0] ev; // error events this cycle
  logic [NEV-1:0] unm_ev; // events that are reported
  logic expire; // replay timer runs out
  logic wr_go; // write performed this cycle
  logic [31:0] wmask; // byte enables as a bit mask
  logic [31:0] wbits; // data bits that are written as one
  logic [NEV-1:0] wsel; // compact bits under strobe and one

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compact vector to register word, reserved bits zero
  function automatic logic [31:0] expand(input logic [NEV-1:0] v);
    logic [31:0] w;
    w = 32'h00000000;
    w[POS_RCV] = v[I_RCV];
    w[POS_TLP] = v[I_TLP];
    w[POS_DLLP] = v[I_DLLP];
    w[POS_RNUM] = v[I_RNUM];
    w[POS_RTO] = v[I_RTO];
    return w;
  endfunction

  // register word to compact vector, reserved bits dropped
  function automatic logic [NEV-1:0] squeeze(input logic [31:0] w);
    logic [NEV-1:0] v;
    v = '0;
    v[I_RCV] = w[POS_RCV];
    v[I_TLP] = w[POS_TLP];
    v[I_DLLP] = w[POS_DLLP];
    v[I_RNUM] = w[POS_RNUM];
    v[I_RTO] = w[POS_RTO];
    return v;
  endfunction

  // read mux; unmapped addresses answer zero
  function automatic logic [31:0] rd_word(input logic [11:0] a,
                                          input pcel_state_type s);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (a)
      OFF_STATUS: d = expand(s.sts);
      OFF_MASK: d = expand(s.msk);
      OFF_IRQ_EN: d = expand(s.ien);
      OFF_IRQ_STS: d = expand(s.ist);
      default: d = 32'h00000000;
    endcase
    return d;
  endfunction

  // addresses that answer okay
  function automatic logic mapped(input logic [11:0] a);
    return (a == OFF_STATUS) || (a == OFF_MASK) || (a == OFF_CAPCTL) ||
           (a == OFF_IRQ_EN) || (a == OFF_IRQ_CLR) || (a == OFF_IRQ_STS);
  endfunction

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  // tlp code errors and bad sequence numbers count against both the
  // dllp and the tlp, as the receiver cannot tell which was hit
  always_comb begin
    ev = '0;
    ev[I_RTO] = expire;
    ev[I_RNUM] = replay_start && (st.rnum == RNUM_LAST);
    ev[I_DLLP] = dllp_crc_bad || tlp_code_err || seq_num_bad;
    ev[I_TLP] = tlp_crc_bad || tlp_code_err || seq_num_bad;
    ev[I_RCV] = rx_code_err || rx_frame_err || tlp_code_err;
    unm_ev = ev & ~st.msk;
  end

  // replay timer runs out after the full span with no ack or nak
  assign expire = tlp_pending && !ack_nak_rx &&
                  (st.timer == REPLAY_CYC - 8'h01);

  // write path helpers
  assign wr_go = st.aw_held && st.w_held && !st.bvalid;
  assign wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}},
                  {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
  assign wbits = st.w_data & wmask;
  assign wsel = squeeze(wbits);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    // replay timer: cleared by ack/nak or when idle, restarts on expiry
    if (!tlp_pending || ack_nak_rx || expire) begin
      next_st.timer = 8'h00;
    end else begin
      next_st.timer = st.timer + 8'h01;
    end
    // replay count: forward progress clears it, it wraps from 3 to 0
    if (ack_nak_rx) begin
      next_st.rnum = 2'h0;
    end else if (replay_start) begin
      next_st.rnum = st.rnum + 2'h1;
    end
    // write address channel
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    // write data channel
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    // response done
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // register write; the event set below wins over a same-cycle clear
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st.aw_addr)
        OFF_STATUS: begin
          next_st.sts = st.sts & ~wsel;
        end
        OFF_MASK: begin
          // only bytes under strobe change
          next_st.msk = (st.msk & ~squeeze(wmask)) | wsel;
        end
        OFF_IRQ_EN: begin
          next_st.ien = (st.ien & ~squeeze(wmask)) | wsel;
        end
        OFF_IRQ_CLR: begin
          next_st.ist = st.ist & ~wsel;
        end
        default: begin
          // cap/control is read-only zero here; unmapped ignored
          next_st.bresp = next_st.bresp;
        end
      endcase
    end
    next_st.sts = next_st.sts | ev;
    next_st.ist = next_st.ist | ev;
    // one message per cycle with any unmasked event
    next_st.err_msg = |unm_ev;
    next_st.irq = |(next_st.ist & next_st.ien);
    // read channel: one read at a time
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word(s_axi_araddr, st);
      next_st.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // ready flags follow the holding state
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
  end

  // ------------------------------------------------------------
  // power-up values
  // ------------------------------------------------------------
  always_comb begin
    por_st = '0;
    por_st.sts = RST_STATUS;
    por_st.msk = RST_MASK;
    por_st.awready = 1'b1;
    por_st.wready = 1'b1;
    por_st.arready = 1'b1;
    // ordinary reset clears everything but the sticky log and mask
    soft_st = por_st;
    soft_st.sts = st.sts;
    soft_st.msk = st.msk;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // ordinary reset keeps the log and mask so software can read what
  // went wrong before the reset; only power-up wipes them
  always_ff @(posedge aclk) begin
    if (!pwr_on_rst_n) begin
      st <= por_st;
    end else if (!aresetn) begin
      st <= soft_st;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cor_err_msg = st.err_msg;
  assign irq = st.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !pwr_on_rst_n);

  logic wr_sts_q; // status write performed last cycle
  always_ff @(posedge aclk) begin
    wr_sts_q <= wr_go && (st.aw_addr == OFF_STATUS);
  end

  sticky_hold_a: assert property (
    (|($past(st.sts) & ~st.sts)) |-> wr_sts_q)
    else $error("status bit fell without a status write");
  sticky_rst_a: assert property (
    @(posedge aclk) disable iff (!pwr_on_rst_n)
    !aresetn |=> (st.sts == $past(st.sts)) && (st.msk == $past(st.msk)))
    else $error("ordinary reset changed status or mask");
  rto_set_a: assert property (
    expire |=> st.sts[I_RTO] && (st.timer == 8'h00))
    else $error("replay timeout not logged");
  timer_span_a: assert property (
    (tlp_pending && !ack_nak_rx && st.timer == 8'h00 && !expire)
    |-> !expire [*8])
    else $error("replay timer expired early");
  rnum_wrap_a: assert property (
    (replay_start && !ack_nak_rx && st.rnum == 2'h3)
    |=> st.rnum == 2'h0 && st.sts[I_RNUM])
    else $error("replay count wrap not logged");
  dllp_set_a: assert property (
    (dllp_crc_bad || tlp_code_err || seq_num_bad) |=> st.sts[I_DLLP])
    else $error("bad dllp not logged");
  tlp_set_a: assert property (
    (tlp_crc_bad || tlp_code_err || seq_num_bad) |=> st.sts[I_TLP])
    else $error("bad tlp not logged");
  rcv_set_a: assert property (
    (rx_code_err || rx_frame_err) |=> st.sts[I_RCV])
    else $error("receiver error not logged");
  msg_mask_a: assert property (
    st.err_msg == $past(|unm_ev))
    else $error("error message disagrees with mask");
  mask_log_a: assert property (
    (|(ev & st.msk)) |=> |(st.sts & $past(ev & st.msk)))
    else $error("masked error not logged");
  mask_por_a: assert property (
    @(posedge aclk) disable iff (1'b0)
    !pwr_on_rst_n |=> st.msk == 5'h00 && st.sts == 5'h00)
    else $error("power-up did not clear mask");
  rsvd_zero_a: assert property (
    st.rvalid |-> (st.rdata & ~IMPL_BITS) == 32'h00000000)
    else $error("reserved bits read nonzero");
  irq_level_a: assert property (
    st.irq == |($past(st.ist & st.ien) | ($past(ev) & $past(st.ien))) ||
    $past(wr_go))
    else $error("interrupt level wrong");

  rto_seen_c: cover property (expire ##1 st.sts[I_RTO]);
  masked_c: cover property (|(ev & st.msk) ##1 !st.err_msg);
  clear_c: cover property (wr_sts_q && st.sts == 5'h00);
  irq_c: cover property ($rose(st.irq));
endmodule
